// *** design/tpg_pkg.sv ***
package tpg_pkg;
    // ----------------------------------------
    // Phase indexing and timing
    // ----------------------------------------
    localparam int TPG_PHASES = 3;
    localparam int TPG_CLK_NS = 100;
    // Least dead time between one switch off and the other on
    localparam int TPG_DEAD_NS = 330;
    // Least time rounds up to whole cycles
    localparam int TPG_DEAD_CYC = (TPG_DEAD_NS + TPG_CLK_NS - 1) / TPG_CLK_NS;
    localparam int TPG_DEAD_W = 3;
    // Reset values
    localparam logic TPG_FAULT_RST = 1'b0;
    localparam logic [TPG_DEAD_W-1:0] TPG_DEAD_RST = 3'h0;

    // Per-phase drive state
    typedef enum logic [1:0] {
        TPG_ST_OFF = 2'b00,
        TPG_ST_DEAD = 2'b01,
        TPG_ST_UPPER = 2'b10,
        TPG_ST_LOWER = 2'b11
    } tpg_state_t;
endpackage

// *** design/tpg_phase_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// Signals between the top and one phase driver
interface tpg_phase_if;
    logic upper_cmd;
    logic lower_cmd;
    logic shutdown;
    logic upper_drv;
    logic lower_drv;
    modport drv (input upper_cmd, input lower_cmd, input shutdown, output upper_drv, output lower_drv);
    modport ctl (output upper_cmd, output lower_cmd, output shutdown, input upper_drv, input lower_drv);
endinterface
`default_nettype wire

// *** design/tpg_phase.sv ***
`timescale 1ns/1ns
`default_nettype none
module tpg_phase (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Phase signals
    tpg_phase_if.drv ph
);
    import tpg_pkg::*;

    // ----------------------------------------
    // Drive state with dead time
    // ----------------------------------------
    tpg_state_t state_r, state_nxt;
    logic [TPG_DEAD_W-1:0] dead_r, dead_nxt; // Dead time counter
    logic want_up, want_lo;

    // Next state: switches only turn on through the dead state, they turn off straight to off
    always_comb begin
        want_up = ph.upper_cmd && !ph.lower_cmd; // see (RQ2) (RQ3)
        want_lo = ph.lower_cmd && !ph.upper_cmd; // see (RQ2) (RQ3)
        state_nxt = state_r;
        dead_nxt = dead_r;
        if (ph.shutdown) begin
            // Fault forces both switches off at once
            state_nxt = TPG_ST_OFF; // see (RQ6) (RQ14)
            dead_nxt = TPG_DEAD_RST;
        end else begin
            case (state_r)
                TPG_ST_OFF: begin
                    if (want_up || want_lo) begin
                        state_nxt = TPG_ST_DEAD; // see (RQ11)
                        dead_nxt = TPG_DEAD_W'(TPG_DEAD_CYC);
                    end
                end
                TPG_ST_DEAD: begin
                    if (!(want_up || want_lo)) begin
                        state_nxt = TPG_ST_OFF;
                    end else if (dead_r > TPG_DEAD_W'(1)) begin
                        dead_nxt = dead_r - TPG_DEAD_W'(1);
                    end else begin
                        state_nxt = want_up ? TPG_ST_UPPER : TPG_ST_LOWER; // see (RQ11)
                    end
                end
                TPG_ST_UPPER: begin
                    if (!want_up) begin
                        state_nxt = TPG_ST_OFF;
                    end
                end
                default: begin
                    if (!want_lo) begin
                        state_nxt = TPG_ST_OFF;
                    end
                end
            endcase
        end
    end

    // Register state
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= TPG_ST_OFF;
            dead_r <= TPG_DEAD_RST;
        end else begin
            state_r <= state_nxt;
            dead_r <= dead_nxt;
        end
    end

    // Outputs straight from the state register
    assign ph.upper_drv = (state_r == TPG_ST_UPPER); // see (RQ2)
    assign ph.lower_drv = (state_r == TPG_ST_LOWER); // see (RQ2)

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_off_gap;
        !ph.upper_drv && !ph.lower_drv;
    endsequence

    chk_no_overlap: assert property (@(posedge clk) disable iff (srst)
        !(ph.upper_drv && ph.lower_drv)) else $error("both switches on"); // see (RQ3)
    chk_dead_gap: assert property (@(posedge clk) disable iff (srst)
        $rose(ph.upper_drv) || $rose(ph.lower_drv) |-> $past(!ph.upper_drv && !ph.lower_drv, 3))
        else $error("dead time too short"); // see (RQ11)
    chk_shut_off: assert property (@(posedge clk) disable iff (srst)
        ph.shutdown |=> s_off_gap) else $error("outputs on after shutdown"); // see (RQ6)
endmodule
`default_nettype wire

// *** design/tpg_top.sv ***
// Operation
// (RQ1) Commands and clear active high, undriven inactive
// (RQ2) Upper command drives upper, lower drives lower
// (RQ3) Both commands together force phase off
// (RQ4) Fault clear resets all three phases
// (RQ5) Fault line active low, only pulled low
// (RQ6) External low on fault line stops all
// (RQ7) Desaturation or undervoltage pulls fault line low
// (RQ8) Indicator active while fault line low
// (RQ9) Fault line is wired-OR of all
// (RQ10) Sync fault line shared wired-OR across phases
// (RQ11) Dead time of 330 ns between switches
// (RQ12) Shutdown runs without controller help
// (RQ13) Controller holds clear during power-on charge
// (RQ14) Fault latched until cleared and gone
`timescale 1ns/1ns
`default_nettype none
module tpg_top (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Phase commands from the controller
    input wire logic phase_u_upper_cmd,
    input wire logic phase_u_lower_cmd,
    input wire logic phase_v_upper_cmd,
    input wire logic phase_v_lower_cmd,
    input wire logic phase_w_upper_cmd,
    input wire logic phase_w_lower_cmd,
    input wire logic fault_clear_in,
    // Per-phase fault detectors, bit 0 is phase U
    input wire logic [tpg_pkg::TPG_PHASES-1:0] desat_det,
    input wire logic [tpg_pkg::TPG_PHASES-1:0] supply_uv_det,
    // Fault and shutdown line, open drain
    input wire logic fault_shutdown_n_in,
    output logic fault_shutdown_n_out,
    output logic fault_shutdown_n_oe_n,
    // Synchronised fault line, open drain
    input wire logic sync_fault_line_in,
    output logic sync_fault_line_out,
    output logic sync_fault_line_oe_n,
    // Gate drive and indicator
    output logic [tpg_pkg::TPG_PHASES-1:0] upper_gate,
    output logic [tpg_pkg::TPG_PHASES-1:0] lower_gate,
    output logic fault_indicator
);
    import tpg_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Pins: three stages, a change counts when stages 2 and 3 agree
    localparam int NIN = 2 * TPG_PHASES + 1 + 2 * TPG_PHASES + 2;
    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] s1_r, s2_r, s3_r, flt_r;
    logic [NIN-1:0] s1_nxt, s2_nxt, s3_nxt, flt_nxt;

    // Undriven pins are pulled to inactive on the board side
    assign pin_raw = {phase_w_lower_cmd, phase_w_upper_cmd, phase_v_lower_cmd, phase_v_upper_cmd,
                      phase_u_lower_cmd, phase_u_upper_cmd, fault_clear_in, desat_det, supply_uv_det,
                      ~fault_shutdown_n_in, sync_fault_line_in}; // see (RQ1) (RQ5)

    // Next values of the sync chain and filtered levels
    always_comb begin
        s1_nxt = pin_raw;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        flt_nxt = flt_r;
        for (int i = 0; i < NIN; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                flt_nxt[i] = s3_r[i];
            end
        end
    end

    // Register the chain, reset to inactive
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            flt_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            flt_r <= flt_nxt;
        end
    end

    // Unpack the filtered levels
    logic [TPG_PHASES-1:0] up_cmd, lo_cmd, desat, uv;
    logic clr, ext_low, sync_in;
    assign {lo_cmd[2], up_cmd[2], lo_cmd[1], up_cmd[1], lo_cmd[0], up_cmd[0]} = flt_r[NIN-1:NIN-6];
    assign clr = flt_r[NIN-7];
    assign desat = flt_r[NIN-8 -: TPG_PHASES];
    assign uv = flt_r[NIN-11 -: TPG_PHASES];
    assign ext_low = flt_r[1];
    assign sync_in = flt_r[0];

    // ----------------------------------------
    // Fault latches, one per phase
    // ----------------------------------------
    logic [TPG_PHASES-1:0] fault_r, fault_nxt;
    logic [TPG_PHASES-1:0] cause;
    logic any_fault, line_low;

    // Next fault state: a present cause wins over the clear
    always_comb begin
        cause = desat | uv; // see (RQ7)
        for (int i = 0; i < TPG_PHASES; i++) begin
            if (cause[i]) begin
                fault_nxt[i] = 1'b1; // see (RQ7) (RQ14)
            end else if (clr) begin
                fault_nxt[i] = 1'b0; // see (RQ4) (RQ14)
            end else begin
                fault_nxt[i] = fault_r[i];
            end
        end
    end

    // Register fault latches
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_r <= {TPG_PHASES{TPG_FAULT_RST}};
        end else begin
            fault_r <= fault_nxt;
        end
    end

    // Own pull on both shared lines; fault line never driven high, sync line driven high
    assign any_fault = |fault_r; // see (RQ9) (RQ10)
    assign fault_shutdown_n_out = 1'b0; // see (RQ5)
    assign fault_shutdown_n_oe_n = ~any_fault; // see (RQ7) (RQ9)
    assign sync_fault_line_out = 1'b1;
    assign sync_fault_line_oe_n = ~any_fault; // see (RQ10)
    // Resolved line: own pull or anyone else's
    assign line_low = any_fault || ext_low || sync_in; // see (RQ9) (RQ10) (RQ12)

    // Indicator registered so it is a clean level
    logic ind_r, ind_nxt;
    always_comb begin
        ind_nxt = any_fault || ext_low; // see (RQ8)
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            ind_r <= 1'b0;
        end else begin
            ind_r <= ind_nxt;
        end
    end
    assign fault_indicator = ind_r;

    // ----------------------------------------
    // Phase drivers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < TPG_PHASES; g++) begin : gen_ph
            tpg_phase_if pif ();
            assign pif.upper_cmd = up_cmd[g];
            assign pif.lower_cmd = lo_cmd[g];
            assign pif.shutdown = line_low; // see (RQ6) (RQ12)
            tpg_phase u_ph (
                .clk(clk),
                .srst(srst),
                .ph(pif.drv)
            );
            assign upper_gate[g] = pif.upper_drv;
            assign lower_gate[g] = pif.lower_drv;
        end
    endgenerate

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_cause;
        |cause;
    endsequence

    chk_fault_pull: assert property (@(posedge clk) disable iff (srst)
        s_cause |=> !fault_shutdown_n_oe_n) else $error("fault line not pulled"); // see (RQ7)
    chk_fault_hold: assert property (@(posedge clk) disable iff (srst)
        any_fault && !clr |=> any_fault) else $error("fault dropped without clear"); // see (RQ14)
    chk_clear_all: assert property (@(posedge clk) disable iff (srst)
        clr && !(|cause) |=> !any_fault) else $error("clear did not reset"); // see (RQ4)
    chk_ind_follow: assert property (@(posedge clk) disable iff (srst)
        ext_low |=> fault_indicator) else $error("indicator missed low line"); // see (RQ8)
    chk_gates_off: assert property (@(posedge clk) disable iff (srst)
        line_low |=> ##1 (upper_gate == '0 && lower_gate == '0))
        else $error("gates on during fault"); // see (RQ6)
    chk_never_high: assert property (@(posedge clk) disable iff (srst)
        fault_shutdown_n_out == 1'b0) else $error("fault line driven high"); // see (RQ5)
endmodule
`default_nettype wire

// *** verification/tpg_ctl_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Controller side and board wiring of the two shared lines
module tpg_ctl_model (
    // Requests from the test sequence, may float
    input wire logic [5:0] cmd_req,
    input wire logic clr_req,
    input wire logic ext_sd_req,
    input wire logic ext_sync_req,
    // Open-drain pins of the device
    input wire logic fsd_out,
    input wire logic fsd_oe_n,
    input wire logic syf_out,
    input wire logic syf_oe_n,
    // Levels seen by the device
    output logic [5:0] cmd,
    output logic clr,
    output logic fsd_line,
    output logic syf_line
);
    // Pull-downs: a floating command reads inactive
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            cmd[i] = (cmd_req[i] === 1'b1);
        end
    end
    // Clear also floats low; held high through reset by the bench
    assign clr = (clr_req === 1'b1);
    // Pull-up; a driver can only pull low, so a high out is ignored
    assign fsd_line = (fsd_oe_n ? 1'b1 : 1'b0) & ~ext_sd_req;
    // Pull-down; wired-OR of phase drivers and outside
    assign syf_line = (syf_oe_n ? 1'b0 : syf_out) | ext_sync_req;
endmodule
`default_nettype wire

// *** verification/tb_tpg_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_tpg_top;
    import tpg_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0, srst = 1'b1, clr_req = 1'b1, ext_sd = 1'b0, ext_sync = 1'b0;
    logic [5:0] cmd_req = 6'h00;
    logic [2:0] desat = 3'h0, uv = 3'h0;
    wire logic [5:0] cmd;
    wire logic clr, fsd_line, syf_line, fsd_out, fsd_oe_n, syf_out, syf_oe_n, ind;
    wire logic [2:0] ug, lg;
    int n_fail = 0, compares = 0, n, k;
    tpg_ctl_model tpg_ctl_model_i (.cmd_req(cmd_req), .clr_req(clr_req), .ext_sd_req(ext_sd),
        .ext_sync_req(ext_sync), .fsd_out(fsd_out), .fsd_oe_n(fsd_oe_n), .syf_out(syf_out),
        .syf_oe_n(syf_oe_n), .cmd(cmd), .clr(clr), .fsd_line(fsd_line), .syf_line(syf_line));
    tpg_top tpg_top_i (.clk(clk), .srst(srst), .phase_u_upper_cmd(cmd[0]), .phase_u_lower_cmd(cmd[1]),
        .phase_v_upper_cmd(cmd[2]), .phase_v_lower_cmd(cmd[3]), .phase_w_upper_cmd(cmd[4]),
        .phase_w_lower_cmd(cmd[5]), .fault_clear_in(clr), .desat_det(desat), .supply_uv_det(uv),
        .fault_shutdown_n_in(fsd_line), .fault_shutdown_n_out(fsd_out), .fault_shutdown_n_oe_n(fsd_oe_n),
        .sync_fault_line_in(syf_line), .sync_fault_line_out(syf_out), .sync_fault_line_oe_n(syf_oe_n),
        .upper_gate(ug), .lower_gate(lg), .fault_indicator(ind));
    // 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic drive(input logic [5:0] c);
        @(posedge clk);
        cmd_req <= c;
    endtask
    // Bounded wait, then compare both gate groups
    task automatic gates(input logic [2:0] eu, input logic [2:0] el);
        @(negedge clk);
        for (int i = 0; i < 30 && !(ug === eu && lg === el); i++) @(negedge clk);
        chk({2'h0, ug, lg}, {2'h0, eu, el});
    endtask
    task automatic wait_oe(input logic e);
        @(negedge clk);
        for (int i = 0; i < 30 && fsd_oe_n !== e; i++) @(negedge clk);
    endtask
    // Long enough to pass the input filter
    task automatic pulse_clr();
        @(posedge clk);
        clr_req <= 1'b1;
        repeat (8) @(posedge clk);
        clr_req <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        // Clear held high across reset so the logic starts clean
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        clr_req <= 1'b0;
        @(negedge clk);
        chk({4'h0, fsd_out, fsd_oe_n, syf_out, syf_oe_n}, 8'h07);
        // Each switch alone, then both at once
        for (k = 0; k < 3; k++) begin
            drive(6'h01 << (2 * k));
            gates(3'h1 << k, 3'h0);
            drive(6'h02 << (2 * k));
            gates(3'h0, 3'h1 << k);
            drive(6'h03 << (2 * k));
            gates(3'h0, 3'h0);
        end
        $display("test commands done");
        // Gap from upper off to lower on
        drive(6'h01);
        gates(3'h1, 3'h0);
        drive(6'h02);
        n = 0;
        for (int i = 0; i < 30 && ug[0] !== 1'b0; i++) @(negedge clk);
        while (n < 30 && lg[0] !== 1'b1) begin
            @(negedge clk);
            n++;
        end
        chk(8'(n >= TPG_DEAD_CYC), 8'h01);
        $display("test dead time done");
        // Every fault cause: latch, clear refused while present, then clear
        for (k = 0; k < 6; k++) begin
            drive(6'h15);
            gates(3'h7, 3'h0);
            @(posedge clk);
            if (k < 3) desat[k] <= 1'b1;
            else uv[k - 3] <= 1'b1;
            gates(3'h0, 3'h0);
            wait_oe(1'b0);
            chk({4'h0, fsd_oe_n, fsd_line, ind, syf_line}, 8'h03);
            pulse_clr();
            chk({7'h0, fsd_oe_n}, 8'h00);
            desat <= 3'h0;
            uv <= 3'h0;
            repeat (10) @(posedge clk);
            chk({6'h0, fsd_oe_n, ug[0]}, 8'h00);
            pulse_clr();
            wait_oe(1'b1);
            chk({6'h0, fsd_oe_n, ind}, 8'h02);
            gates(3'h7, 3'h0);
        end
        $display("test faults done");
        // Outside pulls on both shared lines, driven on the rising edge
        drive(6'h2A);
        gates(3'h0, 3'h7);
        @(posedge clk);
        ext_sd <= 1'b1;
        gates(3'h0, 3'h0);
        chk({6'h0, ind, fsd_oe_n}, 8'h03);
        @(posedge clk);
        ext_sd <= 1'b0;
        pulse_clr();
        gates(3'h0, 3'h7);
        @(posedge clk);
        ext_sync <= 1'b1;
        gates(3'h0, 3'h0);
        @(posedge clk);
        ext_sync <= 1'b0;
        pulse_clr();
        gates(3'h0, 3'h7);
        drive(6'h00);
        gates(3'h0, 3'h0);
        $display("test outside pulls done");
        conclude();
    end
    // Tests need well under a thousand cycles; cut a hang at 30000
    initial begin
        #3000000;
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
